// file: src/nrps_pkg.sv
// shared constants and types of the nand read/program host sequencer
// assumes a single 250 MHz system clock; all pin timing is counted from it
package nrps_pkg;

    // ==================== clock and timing ====================
    localparam int CLK_MHZ      = 250;
    localparam int T_WB_NS      = 100;  // strobe edge to busy / data turnaround guard
    localparam int WB_CYC       = (T_WB_NS * CLK_MHZ + 999) / 1000;
    localparam int TICK_DIV     = 4;    // system cycles per strobe phase
    localparam int LEN_W        = 13;
    localparam int ROW_W        = 17;
    localparam int COL_W        = 13;

    // ==================== address layout ====================
    localparam int PAGE_BITS    = 6;    // in_block_page_bits
    localparam int DISTRICT_BIT = 6;    // block lsb picks the district

    // ==================== command bytes ====================
    localparam logic [7:0] CMD_READ      = 8'h00;
    localparam logic [7:0] CMD_READ_GO   = 8'h30;
    localparam logic [7:0] CMD_COL_RD    = 8'h05;
    localparam logic [7:0] CMD_COL_RD_GO = 8'hE0;
    localparam logic [7:0] CMD_CACHE     = 8'h31;
    localparam logic [7:0] CMD_CACHE_END = 8'h3F;
    localparam logic [7:0] CMD_MULTI_RD  = 8'h60;
    localparam logic [7:0] CMD_LOAD      = 8'h80;
    localparam logic [7:0] CMD_LOAD_2ND  = 8'h81;
    localparam logic [7:0] CMD_COL_WR    = 8'h85;
    localparam logic [7:0] CMD_PROG_GO   = 8'h10;
    localparam logic [7:0] CMD_PROG_HOLD = 8'h11;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_RESET     = 8'hFF;

    // ==================== operations requested by the user ====================
    typedef enum logic [3:0] {
        OP_READ        = 4'h0,
        OP_CACHE       = 4'h1,
        OP_CACHE_LAST  = 4'h2,
        OP_READ_COL    = 4'h3,
        OP_MULTI_READ  = 4'h4,
        OP_PROG_LOAD   = 4'h5,
        OP_PROG_COL    = 4'h6,
        OP_PROG_GO     = 4'h7,
        OP_MULTI_FIRST = 4'h8,
        OP_MULTI_LAST  = 4'h9,
        OP_STATUS      = 4'hA,
        OP_RESET       = 4'hB
    } nrps_op_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD1 = 3'b001,
        ST_ADDR = 3'b011,
        ST_DATA = 3'b010,
        ST_CMD2 = 3'b110,
        ST_WB   = 3'b111,
        ST_RB   = 3'b101,
        ST_DONE = 3'b100
    } nrps_state_type;

endpackage

// file: src/nrps_sync3.sv
// three-flop input synchroniser, one lane per bit
// assumes inputs are asynchronous to clk_sys_i
module nrps_sync3 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             srst_i,
    // async in, settled out
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] sync_o
);

    // ==================== per-bit stages ====================
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        always_ff @(posedge clk_sys_i) begin
            s1_q <= async_i[b];
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
        // change only counts once stages two and three agree
        always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
                sync_o[b] <= rst_val_i[b];
            end else if (s2_q == s3_q) begin
                sync_o[b] <= s3_q;
            end
        end
    end

endmodule

// file: src/nrps_host.sv
// host-side sequencer driving a nand device over its strobe pins
// assumes one device on the bus, pull-up on ready_busy_n, io resolved outside
// ==================== rules ====================
module nrps_host #(
    parameter int DIV = nrps_pkg::TICK_DIV
) (
    // clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       srst_i,
    // user request
    input  wire logic                       op_start_i,
    input  wire nrps_pkg::nrps_op_type      op_i,
    input  wire logic [nrps_pkg::COL_W-1:0] col_i,
    input  wire logic [nrps_pkg::ROW_W-1:0] row_i,
    input  wire logic [nrps_pkg::ROW_W-1:0] row2_i,
    input  wire logic [nrps_pkg::LEN_W-1:0] len_i,
    input  wire logic                       wp_protect_i,
    output logic                            idle_o,
    output logic                            done_o,
    output logic                            err_o,
    output logic                            status_fail_o,
    // program data in
    input  wire logic [7:0]                 wr_data_i,
    input  wire logic                       wr_valid_i,
    output logic                            wr_ready_o,
    // read data out
    output logic [7:0]                      rd_data_o,
    output logic                            rd_valid_o,
    // device pins
    output logic                            ce_n_o,
    output logic                            cle_o,
    output logic                            ale_o,
    output logic                            we_n_o,
    output logic                            read_strobe_n_o,
    output logic                            wp_n_o,
    output logic [7:0]                      shared_byte_port_o,
    output logic                            shared_byte_port_oe_o,
    input  wire logic [7:0]                 shared_byte_port_i,
    input  wire logic                       ready_busy_n_i
);

    // ==================== input synchronisers ====================
    logic [8:0] pins_s;
    nrps_sync3 #(.WIDTH(9)) u_sync (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .async_i   ({ready_busy_n_i, shared_byte_port_i}),
        .rst_val_i (9'h100),
        .sync_o    (pins_s)
    );
    wire       rb_ready = pins_s[8];
    wire [7:0] io_s     = pins_s[7:0];

    // ==================== strobe tick divider ====================
    logic [7:0] div_q;
    wire        tick = (div_q == 8'((DIV) - 1));
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || tick) div_q <= 8'h00;
        else div_q <= div_q + 8'h01;
    end

    // ==================== registers ====================
    nrps_pkg::nrps_state_type state_q;
    nrps_pkg::nrps_op_type    op_q;
    logic [nrps_pkg::COL_W-1:0] col_q;
    logic [nrps_pkg::ROW_W-1:0] row_q;
    logic [nrps_pkg::ROW_W-1:0] row2_q;
    logic [nrps_pkg::ROW_W-1:0] cache_row_q;
    logic [nrps_pkg::ROW_W-1:0] mp_row_q;
    logic [nrps_pkg::LEN_W-1:0] cnt_q;
    logic [2:0] aidx_q;
    logic [1:0] ph_q;
    logic [7:0] wait_q;
    logic       leg_q;
    logic       cache_act_q;
    logic       mp_pend_q;
    logic       prog_open_q;

    // ==================== operation decode ====================
    logic [7:0] c1;
    logic [7:0] c2;
    logic [2:0] nadr;
    logic       has_c2;
    logic       waits;
    logic       rd;
    logic       wr;
    always_comb begin
        c1 = nrps_pkg::CMD_STATUS;
        c2 = nrps_pkg::CMD_READ_GO;
        nadr = 3'd0;
        has_c2 = 1'b0;
        waits = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        unique case (op_q)
            nrps_pkg::OP_READ: begin
                c1 = nrps_pkg::CMD_READ; nadr = 3'd5; has_c2 = 1'b1; waits = 1'b1; rd = 1'b1;
            end
            nrps_pkg::OP_CACHE: begin
                c1 = nrps_pkg::CMD_CACHE; waits = 1'b1; rd = 1'b1;
            end
            nrps_pkg::OP_CACHE_LAST: begin
                c1 = nrps_pkg::CMD_CACHE_END; waits = 1'b1; rd = 1'b1;
            end
            nrps_pkg::OP_READ_COL: begin
                c1 = nrps_pkg::CMD_COL_RD; c2 = nrps_pkg::CMD_COL_RD_GO; nadr = 3'd2; has_c2 = 1'b1; rd = 1'b1;
            end
            nrps_pkg::OP_MULTI_READ: begin
                c1 = nrps_pkg::CMD_MULTI_RD; nadr = 3'd3; has_c2 = 1'b1; waits = 1'b1;
            end
            nrps_pkg::OP_PROG_LOAD: begin
                c1 = nrps_pkg::CMD_LOAD; nadr = 3'd5; wr = 1'b1;
            end
            nrps_pkg::OP_PROG_COL: begin
                c1 = nrps_pkg::CMD_COL_WR; nadr = 3'd2; wr = 1'b1;
            end
            nrps_pkg::OP_PROG_GO: begin
                c1 = nrps_pkg::CMD_PROG_GO; waits = 1'b1;
            end
            nrps_pkg::OP_MULTI_FIRST: begin
                c1 = nrps_pkg::CMD_LOAD; c2 = nrps_pkg::CMD_PROG_HOLD; nadr = 3'd5; has_c2 = 1'b1;
                waits = 1'b1; wr = 1'b1;
            end
            nrps_pkg::OP_MULTI_LAST: begin
                c1 = nrps_pkg::CMD_LOAD_2ND; c2 = nrps_pkg::CMD_PROG_GO; nadr = 3'd5; has_c2 = 1'b1;
                waits = 1'b1; wr = 1'b1;
            end
            nrps_pkg::OP_STATUS: begin
                rd = 1'b1;
            end
            nrps_pkg::OP_RESET: begin
                c1 = nrps_pkg::CMD_RESET; waits = 1'b1;
            end
            default: ;
        endcase
    end

    // ==================== request checks ====================
    wire [nrps_pkg::ROW_W-1:0] next_row = cache_row_q + 17'h00001;
    wire any_cmd   = (op_i == nrps_pkg::OP_STATUS) || (op_i == nrps_pkg::OP_RESET);
    wire same_page = row_i[nrps_pkg::PAGE_BITS-1:0] == row2_i[nrps_pkg::PAGE_BITS-1:0];
    wire two_dist  = row_i[nrps_pkg::DISTRICT_BIT] != row2_i[nrps_pkg::DISTRICT_BIT];
    wire mp_match  = (row_i[nrps_pkg::PAGE_BITS-1:0] == mp_row_q[nrps_pkg::PAGE_BITS-1:0])
                   && (row_i[nrps_pkg::DISTRICT_BIT] != mp_row_q[nrps_pkg::DISTRICT_BIT]);
    wire blk_wrap  = next_row[nrps_pkg::PAGE_BITS-1:0] == 6'h00;
    logic bad;
    always_comb begin
        bad = !rb_ready && !any_cmd;
        if (mp_pend_q && !any_cmd && op_i != nrps_pkg::OP_MULTI_LAST) bad = 1'b1;
        unique case (op_i)
            nrps_pkg::OP_CACHE: if (!cache_act_q || blk_wrap) bad = 1'b1;
            nrps_pkg::OP_CACHE_LAST: if (!cache_act_q) bad = 1'b1;
            nrps_pkg::OP_MULTI_READ: if (!same_page || !two_dist) bad = 1'b1;
            nrps_pkg::OP_PROG_COL, nrps_pkg::OP_PROG_GO: if (!prog_open_q) bad = 1'b1;
            nrps_pkg::OP_MULTI_LAST: if (!mp_pend_q || !mp_match) bad = 1'b1;
            default: ;
        endcase
    end

    // ==================== address byte select ====================
    logic [7:0] abyte;
    wire [nrps_pkg::ROW_W-1:0] arow = leg_q ? row2_q : row_q;
    always_comb begin
        unique case (aidx_q)
            3'd0: abyte = col_q[7:0];
            3'd1: abyte = {3'b000, col_q[12:8]};
            3'd2: abyte = arow[7:0];
            3'd3: abyte = arow[15:8];
            default: abyte = {7'h00, arow[16]};
        endcase
    end

    // ==================== next step ====================
    wire last_addr = aidx_q == ((nadr == 3'd2) ? 3'd1 : 3'd4);
    wire multi_leg = (op_q == nrps_pkg::OP_MULTI_READ) && !leg_q;
    nrps_pkg::nrps_state_type after_cmd;
    assign after_cmd = multi_leg ? nrps_pkg::ST_CMD1 :
                       wr ? nrps_pkg::ST_DATA :
                       has_c2 ? nrps_pkg::ST_CMD2 :
                       (waits || rd) ? nrps_pkg::ST_WB : nrps_pkg::ST_DONE;
    nrps_pkg::nrps_state_type after_wb;
    assign after_wb = waits ? nrps_pkg::ST_RB : rd ? nrps_pkg::ST_DATA : nrps_pkg::ST_DONE;
    wire wr_take = wr_ready_o && wr_valid_i;

    // ==================== sequencer ====================
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q <= nrps_pkg::ST_IDLE;
            op_q <= nrps_pkg::OP_STATUS;
            {col_q, row_q, row2_q, cache_row_q, mp_row_q} <= '0;
            {cnt_q, aidx_q, ph_q, wait_q, leg_q} <= '0;
            {cache_act_q, mp_pend_q, prog_open_q} <= 3'b000;
            {done_o, err_o, status_fail_o, rd_valid_o, wr_ready_o} <= 5'b00000;
            rd_data_o <= 8'h00;
            {cle_o, ale_o, shared_byte_port_oe_o} <= 3'b000;
            {ce_n_o, we_n_o, read_strobe_n_o, wp_n_o, idle_o} <= 5'b11101;
            shared_byte_port_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            err_o <= 1'b0;
            rd_valid_o <= 1'b0;
            idle_o <= (state_q == nrps_pkg::ST_IDLE) && !op_start_i;
            wp_n_o <= !wp_protect_i || (op_q == nrps_pkg::OP_MULTI_READ && state_q != nrps_pkg::ST_IDLE);
            unique case (state_q)
                nrps_pkg::ST_IDLE: begin
                    ce_n_o <= 1'b1;
                    if (op_start_i && bad) err_o <= 1'b1;
                    if (op_start_i && !bad) begin
                        op_q <= op_i;
                        col_q <= col_i;
                        row_q <= row_i;
                        row2_q <= row2_i;
                        cnt_q <= (op_i == nrps_pkg::OP_STATUS) ? 13'd1 : len_i;
                        leg_q <= 1'b0;
                        ph_q <= 2'd0;
                        ce_n_o <= 1'b0;
                        idle_o <= 1'b0;
                        state_q <= nrps_pkg::ST_CMD1;
                    end
                end
                nrps_pkg::ST_CMD1, nrps_pkg::ST_ADDR, nrps_pkg::ST_CMD2: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    if (ph_q == 2'd0) begin
                        cle_o <= state_q != nrps_pkg::ST_ADDR;
                        ale_o <= state_q == nrps_pkg::ST_ADDR;
                        shared_byte_port_oe_o <= 1'b1;
                        shared_byte_port_o <= (state_q == nrps_pkg::ST_CMD1) ? c1 :
                                              (state_q == nrps_pkg::ST_CMD2) ? c2 : abyte;
                        we_n_o <= 1'b0;
                    end else if (ph_q == 2'd1) begin
                        we_n_o <= 1'b1; // device latches on this rising edge; starts here on 30h
                    end else begin
                        ph_q <= 2'd0;
                        {cle_o, ale_o, shared_byte_port_oe_o} <= 3'b000;
                        wait_q <= 8'(nrps_pkg::WB_CYC);
                        if (state_q == nrps_pkg::ST_CMD1) begin
                            aidx_q <= (nadr == 3'd3) ? 3'd2 : 3'd0;
                            state_q <= (nadr != 3'd0) ? nrps_pkg::ST_ADDR : after_cmd;
                        end else if (state_q == nrps_pkg::ST_ADDR) begin
                            aidx_q <= aidx_q + 3'd1;
                            if (last_addr) begin
                                leg_q <= multi_leg;
                                state_q <= after_cmd;
                            end
                        end else begin
                            state_q <= nrps_pkg::ST_WB;
                        end
                    end
                end
                nrps_pkg::ST_WB: begin
                    wait_q <= wait_q - 8'h01;
                    if (wait_q == 8'h00) state_q <= after_wb;
                end
                nrps_pkg::ST_RB: if (rb_ready) state_q <= rd ? nrps_pkg::ST_DATA : nrps_pkg::ST_DONE;
                nrps_pkg::ST_DATA: begin
                    if (cnt_q == 13'd0) begin
                        state_q <= (wr && has_c2) ? nrps_pkg::ST_CMD2 : nrps_pkg::ST_DONE;
                        wr_ready_o <= 1'b0;
                    end else if (wr && ph_q == 2'd0) begin
                        // byte handshake runs per clock so the user can stall
                        wr_ready_o <= !wr_take;
                        if (wr_take) begin
                            shared_byte_port_o <= wr_data_i;
                            shared_byte_port_oe_o <= 1'b1;
                            we_n_o <= 1'b0;
                            ph_q <= 2'd1;
                        end
                    end else if (tick) begin
                        ph_q <= (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
                        if (wr && ph_q == 2'd1) we_n_o <= 1'b1;
                        if (!wr && ph_q == 2'd0) read_strobe_n_o <= 1'b0;
                        if (ph_q == 2'd2) begin
                            cnt_q <= cnt_q - 13'd1;
                            shared_byte_port_oe_o <= 1'b0;
                            if (!wr) begin
                                read_strobe_n_o <= 1'b1;
                                rd_data_o <= io_s;
                                rd_valid_o <= 1'b1;
                                if (op_q == nrps_pkg::OP_STATUS) status_fail_o <= io_s[0];
                            end
                        end
                    end
                end
                nrps_pkg::ST_DONE: begin
                    done_o <= 1'b1;
                    ce_n_o <= 1'b1;
                    state_q <= nrps_pkg::ST_IDLE;
                    unique case (op_q)
                        nrps_pkg::OP_READ, nrps_pkg::OP_MULTI_READ: begin
                            cache_act_q <= 1'b1;
                            cache_row_q <= row_q;
                        end
                        nrps_pkg::OP_CACHE: cache_row_q <= next_row;
                        nrps_pkg::OP_CACHE_LAST: cache_act_q <= 1'b0;
                        nrps_pkg::OP_READ_COL, nrps_pkg::OP_STATUS: ;
                        nrps_pkg::OP_PROG_LOAD: begin
                            prog_open_q <= 1'b1;
                            cache_act_q <= 1'b0;
                        end
                        nrps_pkg::OP_PROG_COL: ;
                        nrps_pkg::OP_MULTI_FIRST: begin
                            mp_pend_q <= 1'b1;
                            mp_row_q <= row_q;
                            cache_act_q <= 1'b0;
                        end
                        default: begin
                            prog_open_q <= 1'b0;
                            mp_pend_q <= 1'b0;
                            cache_act_q <= 1'b0;
                        end
                    endcase
                end
            endcase
        end
    end

endmodule

// file: verification/nrps_host_properties.sv
// pin and handshake checker for the nand host sequencer
// assumes binding onto nrps_host, one clock, synchronous reset
module nrps_host_properties (
    input wire logic       clk_sys_i,
    input wire logic       srst_i,
    input wire logic       op_start_i,
    input wire logic       idle_o,
    input wire logic       done_o,
    input wire logic       err_o,
    input wire logic       rd_valid_o,
    input wire logic       ce_n_o,
    input wire logic       cle_o,
    input wire logic       ale_o,
    input wire logic       we_n_o,
    input wire logic       read_strobe_n_o,
    input wire logic       wp_n_o,
    input wire logic [7:0] shared_byte_port_o,
    input wire logic       shared_byte_port_oe_o,
    input wire logic       ready_busy_n_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // ==================== properties ====================
    property p_rst; $fell(srst_i) |-> ce_n_o && we_n_o && read_strobe_n_o && !shared_byte_port_oe_o; endproperty
    a_rst: assert property (p_rst) else $error("pins not idle after reset");
    property p_take; op_start_i && idle_o |=> err_o || !idle_o; endproperty
    a_take: assert property (p_take) else $error("request neither taken nor refused");
    property p_refuse; err_o |-> ce_n_o && we_n_o; endproperty
    a_refuse: assert property (p_refuse) else $error("refused request touched pins");
    // status reads are legal in busy, so bench keeps them to ready periods
    property p_busy; !ready_busy_n_i [*4] |-> read_strobe_n_o; endproperty
    a_busy: assert property (p_busy) else $error("read strobe while busy");
    property p_we; !we_n_o |-> !ce_n_o && read_strobe_n_o && !(cle_o && ale_o); endproperty
    a_we: assert property (p_we) else $error("bad latch strobe combination");
    property p_hold; $rose(we_n_o) |-> $stable(shared_byte_port_o) && shared_byte_port_oe_o; endproperty
    a_hold: assert property (p_hold) else $error("io moved at latch edge");
    property p_wp; cle_o && !we_n_o && shared_byte_port_o == 8'h60 |-> wp_n_o; endproperty
    a_wp: assert property (p_wp) else $error("write protect low in multi read");
    property p_done; done_o |=> idle_o && !done_o; endproperty
    a_done: assert property (p_done) else $error("done not a pulse before idle");
    property p_rdv; rd_valid_o |=> !rd_valid_o; endproperty
    a_rdv: assert property (p_rdv) else $error("read valid longer than a cycle");
    c_read: cover property (rd_valid_o);
    c_err: cover property (err_o);
    c_busy: cover property ($fell(ready_busy_n_i));
endmodule

bind nrps_host nrps_host_properties nrps_host_properties_i (.*);

// file: verification/nrps_dev_model.sv
// behavioural nand device: command latch, busy, cached serial output, status
// assumes io resolved by the bench; no power-up 00h needed
module nrps_dev_model #(
    parameter int BUSY_NS = 400
) (
    input  wire logic        ce_n_i,
    input  wire logic        cle_i,
    input  wire logic        ale_i,
    input  wire logic        we_n_i,
    input  wire logic        read_strobe_n_i,
    input  wire logic [7:0]  io_i,
    input  wire logic        fail_i,
    output logic      [7:0]  io_o = 8'h00,
    output logic             io_oe_o,
    output logic             ready_busy_n_o = 1'b1,
    output logic      [31:0] cmd_hist_o = '0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [12:0] col_q = '0;
    logic [7:0]  row_q = '0;
    logic [7:0]  buf_q = '0;
    logic [7:0]  cache_q = '0;
    logic [2:0]  addr_q = '0;
    logic        stat_q = 1'b0;
    assign io_oe_o = !ce_n_i && !read_strobe_n_i;
    always @(posedge we_n_i) begin
        if (!ce_n_i && cle_i) begin
            cmd_hist_o <= {cmd_hist_o[23:0], io_i};
            addr_q <= 3'd0;
            stat_q <= (io_i == 8'h70);
            if (io_i inside {8'h30, 8'h31, 8'h3F, 8'h10}) begin
                ready_busy_n_o <= 1'b0;
                ready_busy_n_o <= #(BUSY_NS) 1'b1;
            end
            if (io_i == 8'h30) begin
                cache_q <= row_q;
                buf_q <= row_q;
            end
            if (io_i == 8'h31) begin
                cache_q <= buf_q;
                buf_q <= buf_q + 8'h01;
                col_q <= '0;
            end
            if (io_i == 8'h3F) begin
                cache_q <= buf_q;
                col_q <= '0;
            end
        end else if (!ce_n_i && ale_i) begin
            addr_q <= addr_q + 3'd1;
            if (addr_q == 3'd0) col_q[7:0] <= io_i;
            if (addr_q == 3'd1) col_q[12:8] <= io_i[4:0];
            if (addr_q == 3'd2) row_q <= io_i;
        end
    end
    always @(negedge read_strobe_n_i) begin
        if (!ce_n_i) begin
            io_o <= stat_q ? {7'h70, fail_i} : col_q[7:0] ^ cache_q;
            if (!stat_q) col_q <= col_q + 13'h0001;
        end
    end
endmodule

// file: verification/nrps_host_tb.sv
// self-checking bench for the nand host sequencer against a device model
// assumes one device, ready line driven by the model, io resolved here
module nrps_host_tb;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("Error t=%0t got %0h exp %0h", $time, (a), (e)); end end
    logic clk_sys_i = 1'b0, srst_i = 1'b1, op_start_i = 1'b0, wp_protect_i = 1'b1, fail = 1'b0;
    nrps_pkg::nrps_op_type op_i = nrps_pkg::OP_READ;
    logic [12:0] col_i = '0, len_i = '0;
    logic [16:0] row_i = '0, row2_i = '0;
    logic [7:0] wr_data_i = 8'h00, io_last = 8'h00, h_io, d_io, rd_data_o;
    logic wr_valid_i = 1'b1, idle_o, done_o, err_o, status_fail_o, wr_ready_o, rd_valid_o;
    logic ce_n, cle, ale, we_n, re_n, wp_n, h_oe, d_oe, rb_n;
    logic [31:0] hist;
    wire [7:0] io_bus = h_oe ? h_io : d_oe ? d_io : ~io_last; // released bus shows no stale byte
    int err_total = 0, n_compared = 0;
    logic [7:0] rd_q [$];
    initial forever #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (h_oe || d_oe) io_last <= io_bus;
        if (rd_valid_o) rd_q.push_back(rd_data_o);
        if (wr_valid_i && wr_ready_o) wr_data_i <= wr_data_i + 8'h01;
    end
    nrps_host nrps_host_i (.*, .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n), .read_strobe_n_o(re_n),
        .wp_n_o(wp_n), .shared_byte_port_o(h_io), .shared_byte_port_oe_o(h_oe), .shared_byte_port_i(io_bus),
        .ready_busy_n_i(rb_n));
    nrps_dev_model nrps_dev_model_i (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
        .read_strobe_n_i(re_n), .io_i(io_bus), .fail_i(fail), .io_o(d_io), .io_oe_o(d_oe),
        .ready_busy_n_o(rb_n), .cmd_hist_o(hist));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==================== shared tasks ====================
    task automatic run(input nrps_pkg::nrps_op_type op, input logic [16:0] r, input logic [12:0] c,
                       input logic [12:0] n, input logic refuse);
        int k;
        rd_q.delete();
        op_i = op;
        row_i = r;
        col_i = c;
        len_i = n;
        op_start_i = 1'b1;
        @(posedge clk_sys_i) #1 op_start_i = 1'b0;
        for (k = 0; k < 20000 && done_o !== 1'b1 && err_o !== 1'b1; k++) @(posedge clk_sys_i) #1;
        if (k == 20000) begin
            err_total++;
            final_report();
        end
        `CHK(err_o, refuse)
        @(posedge clk_sys_i) #1;
    endtask
    task automatic chk_rd(input logic [7:0] c, input logic [7:0] p, input int n);
        `CHK(rd_q.size(), n)
        for (int i = 0; i < rd_q.size(); i++) `CHK(rd_q[i], (c + i[7:0]) ^ p)
    endtask
    // ==================== scenarios ====================
    task automatic t_read();
        run(nrps_pkg::OP_READ, 17'h00041, 13'h0003, 13'h0004, 1'b0);
        `CHK(hist[15:0], 16'h0030)
        chk_rd(8'h03, 8'h41, 4);
        run(nrps_pkg::OP_READ_COL, 17'h00041, 13'h0010, 13'h0002, 1'b0);
        `CHK(hist[15:0], 16'h05E0)
        chk_rd(8'h10, 8'h41, 2);
        $display("test read done");
    endtask
    task automatic t_cache();
        run(nrps_pkg::OP_CACHE, 17'h00041, 13'h0000, 13'h0002, 1'b0);
        `CHK(hist[7:0], 8'h31)
        chk_rd(8'h00, 8'h41, 2);
        run(nrps_pkg::OP_CACHE, 17'h00041, 13'h0000, 13'h0002, 1'b0);
        chk_rd(8'h00, 8'h42, 2);
        run(nrps_pkg::OP_CACHE_LAST, 17'h00041, 13'h0000, 13'h0002, 1'b0);
        `CHK(hist[7:0], 8'h3F)
        chk_rd(8'h00, 8'h43, 2);
        run(nrps_pkg::OP_CACHE_LAST, 17'h00041, 13'h0000, 13'h0002, 1'b1);
        run(nrps_pkg::OP_READ, 17'h0007F, 13'h0000, 13'h0000, 1'b0);
        run(nrps_pkg::OP_CACHE, 17'h0007F, 13'h0000, 13'h0000, 1'b1);
        $display("test cache done");
    endtask
    task automatic t_multi();
        row2_i = 17'h00001;
        run(nrps_pkg::OP_MULTI_READ, 17'h00041, 13'h0000, 13'h0001, 1'b0);
        `CHK(hist[23:0], 24'h606030)
        `CHK(rd_q.size(), 0)
        row2_i = 17'h00041;
        run(nrps_pkg::OP_MULTI_READ, 17'h00001, 13'h0000, 13'h0001, 1'b0);
        row2_i = 17'h00042;
        run(nrps_pkg::OP_MULTI_READ, 17'h00001, 13'h0000, 13'h0001, 1'b1);
        row2_i = 17'h000C1;
        run(nrps_pkg::OP_MULTI_READ, 17'h00041, 13'h0000, 13'h0001, 1'b1);
        $display("test multi read done");
    endtask
    task automatic t_prog();
        wp_protect_i = 1'b0;
        run(nrps_pkg::OP_PROG_GO, 17'h00005, 13'h0000, 13'h0000, 1'b1);
        run(nrps_pkg::OP_PROG_LOAD, 17'h00005, 13'h0000, 13'h0003, 1'b0);
        run(nrps_pkg::OP_PROG_COL, 17'h00005, 13'h0020, 13'h0002, 1'b0);
        run(nrps_pkg::OP_PROG_COL, 17'h00005, 13'h0100, 13'h0001, 1'b0);
        run(nrps_pkg::OP_PROG_GO, 17'h00005, 13'h0000, 13'h0000, 1'b0);
        `CHK(hist, 32'h80858510)
        $display("test program done");
    endtask
    task automatic t_mprog();
        run(nrps_pkg::OP_RESET, 17'h00000, 13'h0000, 13'h0000, 1'b0);
        `CHK(hist[7:0], 8'hFF)
        run(nrps_pkg::OP_MULTI_FIRST, 17'h00000, 13'h0000, 13'h0001, 1'b0);
        `CHK(hist[7:0], 8'h11)
        run(nrps_pkg::OP_READ, 17'h00000, 13'h0000, 13'h0001, 1'b1);
        run(nrps_pkg::OP_STATUS, 17'h00000, 13'h0000, 13'h0001, 1'b0);
        `CHK(status_fail_o, 1'b0)
        fail = 1'b1;
        run(nrps_pkg::OP_MULTI_LAST, 17'h00040, 13'h0000, 13'h0001, 1'b0);
        `CHK(hist[15:0], 16'h8110)
        run(nrps_pkg::OP_STATUS, 17'h00000, 13'h0000, 13'h0001, 1'b0);
        `CHK(status_fail_o, 1'b1)
        $display("test multi program done");
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1 srst_i = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1;
        t_read();
        t_cache();
        t_multi();
        t_prog();
        t_mprog();
        final_report();
    end
endmodule
